// file: hdl/poc_path_overhead.sv
// Path overhead error counters and transmit pointer control behind an AXI4-Lite slave.
// Assumes receive reports and the frame start strobe come from logic on ref_clk.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps

module poc_path_overhead #(
	parameter int SNAP_CYCLES_P = poc_pkg::SNAP_CYCLES
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic resetn,
	// Register bus.
	input wire poc_pkg::poc_axi_req_t axiReq,
	output poc_pkg::poc_axi_rsp_t axiRsp,
	// Receive error reports.
	input wire poc_pkg::poc_rx_evt_t rxEvt,
	// Transmit frame timing and overhead controls.
	input wire logic txFrameStart,
	output poc_pkg::poc_tx_out_t txOut
);

	// The snapshot timer is eight bits wide.
	// A longer delay would need a wider timer, and the state struct would grow with it.
	// At 200 MHz the default of 200 cycles gives the one microsecond settling time.
	if (SNAP_CYCLES_P < 1 || SNAP_CYCLES_P > 256) begin : gBadSnap
		$error("SNAP_CYCLES_P must lie between 1 and 256.");
	end

	localparam logic [7:0] SNAP_LOAD = 8'(SNAP_CYCLES_P - 1);

	typedef struct packed {
		poc_pkg::poc_axi_rsp_t rsp;
		logic awHeld;
		logic [poc_pkg::ADDR_W-1:0] awAddr;
		logic wHeld;
		logic [7:0] wData;
		logic wLane0;
		logic adjPermit;
		logic blockMode;
		logic parityCorrupt;
		logic pathAlarm;
		logic ptrForce;
		logic stuffSpacing;
		logic ptrLoad;
		logic ndfInsert;
		logic negPend;
		logic posPend;
		logic [9:0] arbitrary_pointer_value;
		logic [3:0] ndfVal;
		logic [1:0] sizeVal;
		logic [15:0] parityCnt;
		logic [15:0] farEndCnt;
		logic [15:0] paritySnap;
		logic [15:0] farEndSnap;
		logic snapBusy;
		logic [7:0] snapTimer;
		logic [9:0] ptr;
		logic [2:0] stuffGap;
		poc_pkg::poc_tx_out_t tx;
	} poc_state_t;

	poc_state_t s;
	poc_state_t next_s;

	// Number of set bits in one B3 error mask.
	// In bit mode every errored parity bit of a frame counts on its own.
	// The loop unrolls into a small adder tree of at most eight inputs.
	function automatic logic [3:0] countOnes(input logic [7:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++) begin
			n = n + {3'h0, v[i]};
		end
		return n;
	endfunction

	// Add with saturation at the top of the 16-bit range.
	// Software then reads all ones for an interval that overflowed.
	// A wrapped count would look like a small, plausible error figure.
	function automatic logic [15:0] satAdd(input logic [15:0] a, input logic [3:0] b);
		logic [16:0] sum;
		sum = {1'b0, a} + {13'h0000, b};
		return sum[16] ? 16'hFFFF : sum[15:0];
	endfunction

	// Map a byte address onto a register index; misses give mapped low.
	// Each register sits in its own aligned 32-bit word on the bus.
	// Only the low byte lane carries data; the upper lanes are ignored.
	// Unmapped or misaligned accesses are refused with a slave error.
	function automatic logic [7:0] regIndex(input logic [poc_pkg::ADDR_W-1:0] a);
		return a[9:2];
	endfunction

	function automatic logic isMapped(input logic [poc_pkg::ADDR_W-1:0] a);
		logic [7:0] i;
		i = a[9:2];
		if (a[poc_pkg::ADDR_W-1:10] != '0 || a[1:0] != 2'h0) begin
			return 1'b0;
		end
		return i == poc_pkg::IDX_GLOBAL || i == poc_pkg::IDX_ADJ_PERMIT
			|| i == poc_pkg::IDX_PARITY_LO || i == poc_pkg::IDX_PARITY_HI
			|| i == poc_pkg::IDX_FAR_END_LO || i == poc_pkg::IDX_FAR_END_HI
			|| i == poc_pkg::IDX_COUNT_MODE || i == poc_pkg::IDX_ERR_INSERT
			|| i == poc_pkg::IDX_PTR_CTL || i == poc_pkg::IDX_ARBITRARY_POINTER_VALUE_LO
			|| i == poc_pkg::IDX_ARBITRARY_POINTER_VALUE_HI;
	endfunction

	// Next state of the whole block.
	always_comb begin
		logic [3:0] parityInc;
		logic [3:0] farEndInc;
		logic doWrite;
		logic trigger;
		logic [7:0] widx;
		logic [7:0] ridx;
		logic [7:0] rbyte;
		logic [2:0] gapNeed;
		logic stuffOk;
		logic loadOk;
		logic [3:0] ndfSel;
		logic [1:0] sizeSel;
		logic [9:0] ptrNext;
		parityInc = 4'h0;
		farEndInc = 4'h0;
		doWrite = 1'b0;
		trigger = 1'b0;
		widx = regIndex(s.awAddr);
		ridx = regIndex(axiReq.araddr);
		rbyte = 8'h00;
		gapNeed = 3'h0;
		stuffOk = 1'b0;
		loadOk = 1'b0;
		ndfSel = poc_pkg::NORMAL_NDF;
		sizeSel = poc_pkg::NORMAL_SIZE;
		ptrNext = s.ptr;
		next_s = s;

		// Write address and data are caught independently, in either order.
		if (axiReq.awvalid && s.rsp.awready) begin
			next_s.awHeld = 1'b1;
			next_s.awAddr = axiReq.awaddr;
		end
		if (axiReq.wvalid && s.rsp.wready) begin
			next_s.wHeld = 1'b1;
			next_s.wData = axiReq.wdata[7:0];
			next_s.wLane0 = axiReq.wstrb[0];
		end
		if (s.rsp.bvalid && axiReq.bready) begin
			next_s.rsp.bvalid = 1'b0;
		end
		if (s.awHeld && s.wHeld && !s.rsp.bvalid) begin
			doWrite = 1'b1;
			next_s.awHeld = 1'b0;
			next_s.wHeld = 1'b0;
			next_s.rsp.bvalid = 1'b1;
			next_s.rsp.bresp = isMapped(s.awAddr) ? poc_pkg::RESP_OKAY : poc_pkg::RESP_SLVERR;
		end
		// Ready stays low while a held item waits, which back-pressures the master.
		next_s.rsp.awready = !next_s.awHeld && !next_s.rsp.bvalid;
		next_s.rsp.wready = !next_s.wHeld && !next_s.rsp.bvalid;

		// Receive error accumulation; the receive pointer never enters here.
		if (rxEvt.b3Valid) begin
			if (s.blockMode) begin
				parityInc = {3'h0, rxEvt.b3ErrMask != 8'h00};
			end else begin
				parityInc = countOnes(rxEvt.b3ErrMask);
			end
		end
		if (rxEvt.febeValid) begin
			farEndInc = rxEvt.febeCount;
		end
		next_s.parityCnt = satAdd(s.parityCnt, parityInc);
		next_s.farEndCnt = satAdd(s.farEndCnt, farEndInc);

		// Register writes. Stuff bits are set after the frame logic, so a request beats a clear.
		if (doWrite && isMapped(s.awAddr)) begin
			trigger = widx == poc_pkg::IDX_GLOBAL || widx == poc_pkg::IDX_PARITY_LO
				|| widx == poc_pkg::IDX_PARITY_HI || widx == poc_pkg::IDX_FAR_END_LO
				|| widx == poc_pkg::IDX_FAR_END_HI;
			if (s.wLane0) begin
				unique case (widx)
					poc_pkg::IDX_ADJ_PERMIT: begin
						next_s.adjPermit = s.wData[poc_pkg::BIT_ADJ_PERMIT];
					end
					poc_pkg::IDX_COUNT_MODE: begin
						next_s.blockMode = s.wData[poc_pkg::BIT_BLOCK_MODE];
					end
					poc_pkg::IDX_ERR_INSERT: begin
						next_s.parityCorrupt = s.wData[poc_pkg::BIT_PARITY_CORRUPT];
						next_s.pathAlarm = s.wData[poc_pkg::BIT_PATH_ALARM];
					end
					poc_pkg::IDX_PTR_CTL: begin
						next_s.ptrForce = s.wData[poc_pkg::BIT_PTR_FORCE];
						next_s.stuffSpacing = s.wData[poc_pkg::BIT_STUFF_SPACING];
						next_s.ptrLoad = s.wData[poc_pkg::BIT_PTR_LOAD];
						next_s.ndfInsert = s.wData[poc_pkg::BIT_NDF_INSERT];
					end
					poc_pkg::IDX_ARBITRARY_POINTER_VALUE_LO: begin
						next_s.arbitrary_pointer_value[7:0] = s.wData;
					end
					poc_pkg::IDX_ARBITRARY_POINTER_VALUE_HI: begin
						next_s.ndfVal = s.wData[7:4];
						next_s.sizeVal = s.wData[3:2];
						next_s.arbitrary_pointer_value[9:8] = s.wData[1:0];
					end
					default: begin
					end
				endcase
			end
		end

		// Snapshot timer; a trigger during a running delay joins that snapshot.
		// Both counters are copied at the same cycle, so low and high bytes never tear.
		// A merged trigger does not restart the delay.
		// The timer counts down from the load value and fires on reaching zero.
		if (trigger && !s.snapBusy) begin
			next_s.snapBusy = 1'b1;
			next_s.snapTimer = SNAP_LOAD;
		end else if (s.snapBusy) begin
			if (s.snapTimer == 8'h00) begin
				next_s.snapBusy = 1'b0;
				// Errors seen in this very cycle open the new interval.
				next_s.paritySnap = s.parityCnt;
				next_s.parityCnt = {12'h000, parityInc};
				next_s.farEndSnap = s.farEndCnt;
				next_s.farEndCnt = {12'h000, farEndInc};
			end else begin
				next_s.snapTimer = s.snapTimer - 8'h01;
			end
		end

		// Stuff pulses last one cycle.
		next_s.tx.posStuff = 1'b0;
		next_s.tx.negStuff = 1'b0;

		// Transmit overhead is rebuilt only at a frame start.
		// Control bits written mid-frame therefore wait for the next boundary.
		// Priority runs alarm, load, force, positive stuff, negative stuff, normal.
		// The stuff gap counter rests at seven so that it never wraps.
		// A refused load value falls through to force, stuff or normal, sent with the normal flag and sizeVal as size bits.
		if (txFrameStart) begin
			gapNeed = s.stuffSpacing ? poc_pkg::STUFF_GAP_SPACED : poc_pkg::STUFF_GAP_NORMAL;
			stuffOk = s.stuffGap >= gapNeed - 3'h1;
			loadOk = s.arbitrary_pointer_value != 10'h000 && s.arbitrary_pointer_value <= poc_pkg::PTR_MAX;
			if (!s.ptrLoad && s.ndfInsert) begin
				ndfSel = s.ndfVal;
			end
			if (s.ptrLoad || s.ndfInsert || s.ptrForce) begin
				sizeSel = s.sizeVal;
			end
			next_s.stuffGap = (s.stuffGap == 3'h7) ? 3'h7 : s.stuffGap + 3'h1;
			next_s.tx.b3Invert = s.parityCorrupt;
			next_s.tx.pathAlarm = s.pathAlarm;
			if (s.pathAlarm) begin
				// Alarm replaces the whole pointer, so pending stuffs wait.
				next_s.tx.h1 = 8'hFF;
				next_s.tx.h2 = 8'hFF;
			end else if (s.ptrLoad && loadOk) begin
				// Only the transmit pointer moves; receive counting is separate.
				ptrNext = s.arbitrary_pointer_value;
				next_s.tx.h1 = {s.ndfVal, sizeSel, s.arbitrary_pointer_value[9:8]};
				next_s.tx.h2 = s.arbitrary_pointer_value[7:0];
			end else if (s.ptrForce) begin
				// Diagnostic force leaves the running pointer and flag choice alone.
				next_s.tx.h1 = {ndfSel, sizeSel, s.arbitrary_pointer_value[9:8]};
				next_s.tx.h2 = s.arbitrary_pointer_value[7:0];
			end else if (s.posPend && stuffOk) begin
				next_s.tx.h1 = {ndfSel, sizeSel, s.ptr[9:8] ^ poc_pkg::I_MASK[9:8]};
				next_s.tx.h2 = s.ptr[7:0] ^ poc_pkg::I_MASK[7:0];
				next_s.tx.posStuff = 1'b1;
				next_s.posPend = 1'b0;
				next_s.stuffGap = 3'h0;
				ptrNext = (s.ptr == poc_pkg::PTR_MAX) ? 10'h000 : s.ptr + 10'h001;
			end else if (s.negPend && stuffOk) begin
				next_s.tx.h1 = {ndfSel, sizeSel, s.ptr[9:8] ^ poc_pkg::D_MASK[9:8]};
				next_s.tx.h2 = s.ptr[7:0] ^ poc_pkg::D_MASK[7:0];
				next_s.tx.negStuff = 1'b1;
				next_s.negPend = 1'b0;
				next_s.stuffGap = 3'h0;
				ptrNext = (s.ptr == 10'h000) ? poc_pkg::PTR_MAX : s.ptr - 10'h001;
			end else begin
				next_s.tx.h1 = {ndfSel, sizeSel, s.ptr[9:8]};
				next_s.tx.h2 = s.ptr[7:0];
			end
			next_s.ptr = ptrNext;
		end

		// Stuff requests are taken after the frame logic so a new one is never lost.
		if (doWrite && s.wLane0 && widx == poc_pkg::IDX_PTR_CTL && s.adjPermit) begin
			if (s.wData[poc_pkg::BIT_NEG_STUFF]) begin
				next_s.negPend = 1'b1;
			end
			if (s.wData[poc_pkg::BIT_POS_STUFF]) begin
				next_s.posPend = 1'b1;
			end
		end

		// Read channel: one read at a time, answered the cycle after it is taken.
		// The read data stand until the master accepts them.
		// Index zero only triggers snapshots, so it reads as zero.
		// Count bytes come from the snapshot, never from the live counters.
		if (s.rsp.rvalid && axiReq.rready) begin
			next_s.rsp.rvalid = 1'b0;
		end
		if (axiReq.arvalid && s.rsp.arready) begin
			unique case (ridx)
				poc_pkg::IDX_ADJ_PERMIT: rbyte = {2'h0, s.adjPermit, 5'h00};
				poc_pkg::IDX_PARITY_LO: rbyte = s.paritySnap[7:0];
				poc_pkg::IDX_PARITY_HI: rbyte = s.paritySnap[15:8];
				poc_pkg::IDX_FAR_END_LO: rbyte = s.farEndSnap[7:0];
				poc_pkg::IDX_FAR_END_HI: rbyte = s.farEndSnap[15:8];
				poc_pkg::IDX_COUNT_MODE: rbyte = {2'h0, s.blockMode, 5'h00};
				poc_pkg::IDX_ERR_INSERT: rbyte = {6'h00, s.parityCorrupt, s.pathAlarm};
				poc_pkg::IDX_PTR_CTL: rbyte = {1'b0, s.ptrForce, s.stuffSpacing, s.ptrLoad,
					s.ndfInsert, s.negPend, s.posPend, 1'b0};
				poc_pkg::IDX_ARBITRARY_POINTER_VALUE_LO: rbyte = s.arbitrary_pointer_value[7:0];
				poc_pkg::IDX_ARBITRARY_POINTER_VALUE_HI: rbyte = {s.ndfVal, s.sizeVal, s.arbitrary_pointer_value[9:8]};
				default: rbyte = 8'h00;
			endcase
			next_s.rsp.rvalid = 1'b1;
			next_s.rsp.rdata = {24'h000000, rbyte};
			next_s.rsp.rresp = isMapped(axiReq.araddr) ? poc_pkg::RESP_OKAY
				: poc_pkg::RESP_SLVERR;
		end
		next_s.rsp.arready = !next_s.rsp.rvalid;
	end

	// State register; reset is synchronous and loads constants only.
	// Ready signals are low during reset and rise at the first edge after release.
	// The pointer bytes leave reset showing the normal flag pattern.
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			s <= '0;
			s.ndfVal <= poc_pkg::RST_NDF;
			s.sizeVal <= poc_pkg::RST_SIZE;
			s.arbitrary_pointer_value <= poc_pkg::RST_ARBITRARY_POINTER_VALUE;
			s.paritySnap <= poc_pkg::RST_COUNT;
			s.farEndSnap <= poc_pkg::RST_COUNT;
			s.stuffGap <= poc_pkg::RST_STUFF_GAP;
			s.tx.h1 <= {poc_pkg::NORMAL_NDF, poc_pkg::NORMAL_SIZE, 2'h0};
		end else begin
			s <= next_s;
		end
	end

	assign axiRsp = s.rsp;
	assign txOut = s.tx;

endmodule

// file: common/poc_pkg.sv
// Shared constants and carrier types for the path overhead control slice.
// Assumes one 200 MHz byte clock and an AXI4-Lite master with 32-bit data.
package poc_pkg;

	// Bus geometry.
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// Register indices; the byte address is four times the index.
	localparam logic [7:0] IDX_GLOBAL = 8'h00;
	localparam logic [7:0] IDX_ADJ_PERMIT = 8'h05;
	localparam logic [7:0] IDX_PARITY_LO = 8'h38;
	localparam logic [7:0] IDX_PARITY_HI = 8'h39;
	localparam logic [7:0] IDX_FAR_END_LO = 8'h3A;
	localparam logic [7:0] IDX_FAR_END_HI = 8'h3B;
	localparam logic [7:0] IDX_COUNT_MODE = 8'h3D;
	localparam logic [7:0] IDX_ERR_INSERT = 8'h40;
	localparam logic [7:0] IDX_PTR_CTL = 8'h41;
	localparam logic [7:0] IDX_ARBITRARY_POINTER_VALUE_LO = 8'h45;
	localparam logic [7:0] IDX_ARBITRARY_POINTER_VALUE_HI = 8'h46;

	// Field positions.
	localparam int BIT_ADJ_PERMIT = 5;
	localparam int BIT_BLOCK_MODE = 5;
	localparam int BIT_PARITY_CORRUPT = 1;
	localparam int BIT_PATH_ALARM = 0;
	localparam int BIT_PTR_FORCE = 6;
	localparam int BIT_STUFF_SPACING = 5;
	localparam int BIT_PTR_LOAD = 4;
	localparam int BIT_NDF_INSERT = 3;
	localparam int BIT_NEG_STUFF = 2;
	localparam int BIT_POS_STUFF = 1;

	// Reset values.
	localparam logic [3:0] RST_NDF = 4'h9;
	localparam logic [1:0] RST_SIZE = 2'h0;
	localparam logic [9:0] RST_ARBITRARY_POINTER_VALUE = 10'h000;
	localparam logic [15:0] RST_COUNT = 16'h0000;
	localparam logic [2:0] RST_STUFF_GAP = 3'h7;

	// Pointer byte constants.
	localparam logic [3:0] NORMAL_NDF = 4'h6;
	localparam logic [1:0] NORMAL_SIZE = 2'h0;
	localparam logic [9:0] PTR_MAX = 10'h30D;
	localparam logic [9:0] I_MASK = 10'h2AA;
	localparam logic [9:0] D_MASK = 10'h155;

	// Stuff spacing in frames.
	localparam logic [2:0] STUFF_GAP_NORMAL = 3'h2;
	localparam logic [2:0] STUFF_GAP_SPACED = 3'h4;

	// Snapshot delay after a triggering write.
	localparam int SNAP_DELAY_NS = 1000;
	localparam int CLK_FREQ_MHZ = 200;
	localparam int SNAP_CYCLES = SNAP_DELAY_NS * CLK_FREQ_MHZ / 1000;

	// AXI responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// AXI4-Lite master-to-slave signals.
	typedef struct packed {
		logic awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [DATA_W-1:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [ADDR_W-1:0] araddr;
		logic rready;
	} poc_axi_req_t;

	// AXI4-Lite slave-to-master signals.
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0] rresp;
	} poc_axi_rsp_t;

	// Per-frame error reports from the receive path overhead logic.
	typedef struct packed {
		logic b3Valid;
		logic [7:0] b3ErrMask;
		logic febeValid;
		logic [3:0] febeCount;
	} poc_rx_evt_t;

	// Transmit overhead controls, updated at frame boundaries.
	typedef struct packed {
		logic [7:0] h1;
		logic [7:0] h2;
		logic b3Invert;
		logic pathAlarm;
		logic posStuff;
		logic negStuff;
	} poc_tx_out_t;

endpackage

// file: verif/poc_path_overhead_asserts.sv
// Checker for the path overhead slice; it sees only the top module ports.
// Assumes one clock domain with the synchronous active-low reset.
`timescale 1ns/1ps
module poc_path_overhead_asserts #(
	parameter int SNAP_CYCLES_P = 4
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic resetn,
	// Watched ports.
	input wire poc_pkg::poc_axi_req_t axiReq,
	input wire poc_pkg::poc_axi_rsp_t axiRsp,
	input wire poc_pkg::poc_rx_evt_t rxEvt,
	input wire logic txFrameStart,
	input wire poc_pkg::poc_tx_out_t txOut
);
	logic [2:0] sinceStuff;
	logic stuff;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);
	assign stuff = txOut.posStuff || txOut.negStuff;
	// Frame starts since the last stuff; it rests at seven so it never wraps.
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			sinceStuff <= 3'h7;
		end else if (stuff) begin
			sinceStuff <= 3'h0;
		end else if (txFrameStart && sinceStuff != 3'h7) begin
			sinceStuff <= sinceStuff + 3'h1;
		end
	end
	// A write is taken on both channels, then answered after one held cycle.
	sequence s_wr_taken;
		axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready;
	endsequence
	sequence s_wr_answer;
		!axiRsp.awready ##1 axiRsp.bvalid;
	endsequence
	a_write_answer: assert property (s_wr_taken |=> s_wr_answer)
		else $error("write not answered in time");
	a_resp_taken: assert property (axiRsp.bvalid && axiReq.bready |=> !axiRsp.bvalid)
		else $error("write response not retired");
	a_read_answer: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
		else $error("read not answered in one cycle");
	a_upper_zero: assert property (axiRsp.rvalid |-> axiRsp.rdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	a_unmapped_read: assert property (
		axiReq.arvalid && axiRsp.arready && axiReq.araddr == 12'h004
		|=> axiRsp.rresp == poc_pkg::RESP_SLVERR && axiRsp.rdata == 32'h0)
		else $error("unmapped read not refused");
	a_frame_update: assert property (
		!$past(txFrameStart) |-> $stable({txOut.h1, txOut.h2, txOut.b3Invert, txOut.pathAlarm}))
		else $error("overhead changed inside a frame");
	a_stuff_pulse: assert property (stuff |-> $past(txFrameStart) ##1 !stuff)
		else $error("stuff pulse misplaced");
	a_stuff_spacing: assert property (stuff |-> sinceStuff >= 3'h2)
		else $error("stuffs too close together");
	a_alarm_ones: assert property (
		txOut.pathAlarm |-> txOut.h1 == 8'hFF && txOut.h2 == 8'hFF && !stuff)
		else $error("alarm frame not all ones");
endmodule

bind poc_path_overhead poc_path_overhead_asserts #(.SNAP_CYCLES_P(SNAP_CYCLES_P)) u_asserts (
	.ref_clk(ref_clk), .resetn(resetn), .axiReq(axiReq), .axiRsp(axiRsp), .rxEvt(rxEvt),
	.txFrameStart(txFrameStart), .txOut(txOut));

// file: verif/poc_line_model.sv
// Line-side model: transmit frame timing and received error reports.
// Assumes the slice shares ref_clk; a frame lasts FRAME_LEN cycles.
`timescale 1ns/1ps
module poc_line_model #(
	parameter int FRAME_LEN = 16
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic resetn,
	// Line side.
	output poc_pkg::poc_rx_evt_t rxEvt,
	output logic txFrameStart
);
	int phase = 0;
	initial begin
		rxEvt = '0;
		txFrameStart = 1'h0;
	end
	// Frames run freely, but no start is given while the slice is in reset.
	always @(posedge ref_clk) begin
		phase <= (phase + 1) % FRAME_LEN;
		txFrameStart <= resetn && phase == 0;
	end
	// One frame of received errors; the fields are junk between pulses.
	task automatic report(input logic [7:0] mask, input logic [3:0] febe);
		@(posedge ref_clk);
		rxEvt <= '{1'h1, mask, 1'h1, febe};
		@(posedge ref_clk);
		rxEvt <= '{1'h0, ~mask, 1'h0, ~febe};
	endtask
endmodule

// file: verif/tb_path_overhead_err_count_and_pointer_ctl.sv
// Self-checking bench for the path overhead slice with its line model.
// Assumes a four-cycle snapshot delay and 16-cycle frames.
`timescale 1ns/1ps
module tb_path_overhead_err_count_and_pointer_ctl;
	localparam int SNAP = 4;
	logic ref_clk;
	logic resetn;
	poc_pkg::poc_axi_req_t req;
	poc_pkg::poc_axi_rsp_t rsp;
	poc_pkg::poc_rx_evt_t rxEvt;
	logic txFrameStart;
	poc_pkg::poc_tx_out_t txOut;
	int fails = 0;
	int compares = 0;
	int g;
	logic [7:0] stuff_spacing_select;
	logic [7:0] rst [5] = '{8'h3A, 8'h3B, 8'h3D, 8'h40, 8'h41};
	logic [7:0] trig [5] = '{8'h00, 8'h38, 8'h39, 8'h3A, 8'h3B};
	logic [9:0] bad [2] = '{10'h30E, 10'h000};

	poc_path_overhead #(.SNAP_CYCLES_P(SNAP)) u_dut (.ref_clk(ref_clk), .resetn(resetn),
		.axiReq(req), .axiRsp(rsp), .rxEvt(rxEvt), .txFrameStart(txFrameStart), .txOut(txOut));
	poc_line_model u_line (.ref_clk(ref_clk), .resetn(resetn), .rxEvt(rxEvt),
		.txFrameStart(txFrameStart));

	// The 200 MHz clock.
	initial begin
		ref_clk = 1'h0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
		end
	endtask

	task automatic results();
		$display("compares %0d, fails %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// One write; each channel drops its valid at the edge that takes it.
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e = 2'h0);
		int n;
		n = 0;
		@(posedge ref_clk);
		req.awvalid <= 1'h1;
		req.awaddr <= {2'h0, a, 2'h0};
		req.wvalid <= 1'h1;
		req.wdata <= {24'h0, d};
		req.bready <= 1'h1;
		do begin
			@(posedge ref_clk);
			n++;
			if (req.awvalid && rsp.awready) req.awvalid <= 1'h0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'h0;
		end while (!rsp.bvalid && n < 64);
		req.bready <= 1'h0;
		chk("bresp", {rsp.bvalid, rsp.bresp}, {1'h1, e});
	endtask

	// One read, compared at the edge that delivers it.
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] e = 2'h0);
		int n;
		n = 0;
		@(posedge ref_clk);
		req.arvalid <= 1'h1;
		req.araddr <= {2'h0, a, 2'h0};
		req.rready <= 1'h1;
		do begin
			@(posedge ref_clk);
			n++;
			if (req.arvalid && rsp.arready) req.arvalid <= 1'h0;
		end while (!rsp.rvalid && n < 64);
		req.rready <= 1'h0;
		chk("rdata", rsp.rdata, x);
		chk("rresp", {rsp.rvalid, rsp.rresp}, {1'h1, e});
	endtask

	// Waits for a frame start, then lets the new overhead settle.
	task automatic nxt();
		do @(posedge ref_clk); while (!txFrameStart);
		#1;
	endtask

	// Counts frames up to a stuff pulse, giving up after eight.
	task automatic sw(output int k);
		k = 0;
		do begin
			nxt();
			k++;
		end while (!(txOut.posStuff || txOut.negStuff) && k < 8);
	endtask

	// Reset, registers and counters first, then the transmit overhead.
	initial begin
		req = '0;
		req.wstrb = 4'hF;
		resetn = 1'h0;
		repeat (20) @(posedge ref_clk);
		resetn <= 1'h1;
		foreach (rst[i]) rd(rst[i], 32'h0);
		chk("h1", txOut.h1, 8'h60);
		rd(8'h01, 32'h0, poc_pkg::RESP_SLVERR);
		wr(8'h01, 8'h5A, poc_pkg::RESP_SLVERR);
		foreach (trig[i]) begin
			for (int e = 0; e <= i; e++) u_line.report(8'h03, 4'h3);
			wr(trig[i], 8'hFF);
			repeat (SNAP + 4) @(posedge ref_clk);
			rd(8'h38, 2 * (i + 1));
			rd(8'h3A, 3 * (i + 1));
			rd(8'h3B, 32'h0);
		end
		wr(8'h3D, 8'h20);
		rd(8'h3D, 32'h20);
		u_line.report(8'hFF, 4'h0);
		u_line.report(8'h00, 4'h0);
		u_line.report(8'h81, 4'h1);
		wr(8'h00, 8'h00);
		repeat (SNAP + 4) @(posedge ref_clk);
		rd(8'h38, 32'h2);
		wr(8'h3D, 8'h00);
		repeat (8200) u_line.report(8'hFF, 4'hF);
		wr(8'h00, 8'h00);
		repeat (SNAP + 4) @(posedge ref_clk);
		for (int a = 8'h38; a < 8'h3C; a++) rd(a[7:0], 32'hFF);
		wr(8'h40, 8'h02);
		nxt();
		chk("b3", {txOut.b3Invert, txOut.pathAlarm}, 2'h2);
		wr(8'h40, 8'h01);
		nxt();
		chk("alarm", {txOut.pathAlarm, txOut.h1, txOut.h2}, 17'h1FFFF);
		wr(8'h40, 8'h00);
		wr(8'h45, 8'h0D);
		wr(8'h46, 8'hA7);
		wr(8'h41, 8'h10);
		nxt();
		chk("load", {txOut.h1, txOut.h2}, 16'hA70D);
		foreach (bad[i]) begin
			wr(8'h45, bad[i][7:0]);
			wr(8'h46, {6'h29, bad[i][9:8]});
			wr(8'h41, 8'h18);
			nxt();
			chk("badload", {txOut.h1[7:4], txOut.h1[1:0], txOut.h2}, 16'h1B0D);
		end
		wr(8'h45, 8'h55);
		wr(8'h46, 8'hC6);
		wr(8'h41, 8'h40);
		nxt();
		chk("force", {txOut.h1, txOut.h2}, 16'h6655);
		wr(8'h41, 8'h48);
		nxt();
		chk("forceflag", {txOut.h1, txOut.h2}, 16'hC655);
		wr(8'h41, 8'h08);
		nxt();
		chk("flag", {txOut.h1, txOut.h2}, 16'hC70D);
		wr(8'h41, 8'h00);
		nxt();
		chk("normal", {txOut.h1, txOut.h2}, 16'h630D);
		// Stuffs are refused without the permit bit, then spaced as selected.
		wr(8'h41, 8'h02);
		rd(8'h41, 32'h0);
		sw(g);
		chk("nostuff", g, 8);
		wr(8'h05, 8'h20);
		for (int s = 0; s < 2; s++) begin
			stuff_spacing_select = s ? 8'h20 : 8'h00;
			wr(8'h41, stuff_spacing_select | 8'h04);
			sw(g);
			chk("neg", {txOut.negStuff, txOut.h1[1:0], txOut.h2}, {1'h1, 10'h30D ^ poc_pkg::D_MASK});
			wr(8'h41, stuff_spacing_select | 8'h02);
			rd(8'h41, stuff_spacing_select | 8'h02);
			sw(g);
			chk("gap", g, 2 + 2 * s);
			chk("pos", {txOut.posStuff, txOut.h1[1:0], txOut.h2}, {1'h1, 10'h30C ^ poc_pkg::I_MASK});
			nxt();
			chk("ptr", {txOut.h1, txOut.h2}, 16'h630D);
		end
		rd(8'h41, 32'h20);
		results();
	end

	// The run needs about 17,000 cycles; this limit leaves a wide margin.
	initial begin
		#300000;
		fails++;
		results();
	end
endmodule
